// ==== include/nfh_regs.svh ====
/*
 * timing constants for the host-side nand sequencer (nfh).
 * assumes a 20 MHz clk; counts derive from ns/us figures.
 */
`ifndef NFH_REGS_SVH
`define NFH_REGS_SVH

`define NFH_CLK_PERIOD_NS 50
// write_high_to_busy_time, ns, longest
`define NFH_WB_NS 100
`define NFH_WB_CYC ((`NFH_WB_NS + `NFH_CLK_PERIOD_NS - 1) / `NFH_CLK_PERIOD_NS)
// address_to_data_gap, ns, least
`define NFH_ADL_NS 70
`define NFH_ADL_CYC ((`NFH_ADL_NS + `NFH_CLK_PERIOD_NS - 1) / `NFH_CLK_PERIOD_NS)
// write cycle half period, ns, least (50 ns cycle)
`define NFH_WC_NS 25
`define NFH_WC_CYC ((`NFH_WC_NS + `NFH_CLK_PERIOD_NS - 1) / `NFH_CLK_PERIOD_NS)
// reset busy at power-up, us
`define NFH_RST_US 1000
`define NFH_RST_CYC (`NFH_RST_US * 1000 / `NFH_CLK_PERIOD_NS)
// partial_program_limit
`define NFH_NOP_MAX 4
// spare-area marker of a good block
`define NFH_GOOD_MARK 8'h00_FF
// command codes
`define NFH_CMD_RESET 8'h00_FF
`define NFH_CMD_STATUS 8'h00_70
// status ready bit position
`define NFH_ST_RDY 5
`define NFH_ST_FAIL 0

`endif

// ==== include/nfh_pkg.sv ====
/*
 * types for the host-side nand sequencer.
 * assumes nfh_regs.svh is included by the design file.
 */
package nfh_pkg;
	typedef enum logic [1:0] {
		NFH_PH_CMD,
		NFH_PH_ADDR,
		NFH_PH_DATA,
		NFH_PH_END
	} nfh_phase_t;
endpackage

// ==== rtl/nfh_host.sv ====
/*
 * host controller that drives an 8-bit async nand flash over its pins.
 * user side issues one cycle at a time (command, address, data write, data read).
 * assumes ready_busy_out arrives asynchronously; io is a split tri-state bus.
 */
// Overview of operation
// - no command within busy assert window
// - at most 4 partial programs per page; nfh_host counts only the latest programmed page
// - 70 ns address to data gap
// - scan markers before program or erase
// - check status after program and erase
// - host applies ecc per 528 bytes; nfh_host itself has no ecc logic
// - first command reset, then wait
`include "nfh_regs.svh"

module nfh_host import nfh_pkg::*; #(
	parameter int RST_WAIT_CYC = `NFH_RST_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// user request
	input wire logic req_valid,
	input wire nfh_phase_t req_phase,
	input wire logic req_read,
	input wire logic [7:0] req_data,
	output logic req_ready,
	output logic [7:0] rsp_data,
	output logic rsp_valid,
	output logic bad_mark,
	output logic op_fail,
	output logic init_done,
	// flash pins
	output logic ce_n,
	output logic cle,
	output logic ale,
	output logic we_n,
	output logic re_n,
	output logic wp_n,
	input wire logic [7:0] io_in,
	output logic [7:0] io_out,
	output logic io_oe,
	input wire logic ready_busy_out
);
	typedef enum logic [2:0] {
		NFH_S_PWR,
		NFH_S_IDLE,
		NFH_S_LOW,
		NFH_S_HIGH,
		NFH_S_WB,
		NFH_S_WAIT
	} nfh_state_t;

	// rb passes three flops; change counts once second and third agree
	logic rb1_q, rb2_q, rb3_q, rb_q;
	logic rb1_d, rb2_d, rb3_d, rb_d;
	nfh_state_t st_q, st_d;
	logic [31:0] cnt_q, cnt_d;
	logic ce_n_q, cle_q, ale_q, we_n_q, re_n_q, io_oe_q, ready_q, rv_q, bad_q, fail_q, init_q, rst_sent_q;
	logic ce_n_d, cle_d, ale_d, we_n_d, re_n_d, io_oe_d, ready_d, rv_d, bad_d, fail_d, init_d, rst_sent_d;
	logic [7:0] io_q, io_d, rsp_q, rsp_d;
	logic last_addr_q, last_addr_d, rd_q, rd_d, is_status_q, is_status_d;
	// partial program bookkeeping; only the latest programmed page is tracked
	logic [7:0] last_cmd_q, last_cmd_d;
	logic [15:0] row_q, row_d, pp_row_q, pp_row_d;
	logic [2:0] pp_cnt_q, pp_cnt_d;
	logic over_nop;

	function automatic logic starts_busy(input logic cl, input logic [7:0] v);
		// confirm commands that make the flash go busy
		return cl && (v == 8'h00_30 || v == 8'h00_31 || v == 8'h00_10 || v == 8'h00_15 ||
			v == 8'h00_D0 || v == 8'h00_35 || v == 8'h00_3F || v == `NFH_CMD_RESET ||
			v == 8'h00_EE || v == 8'h00_EF);
	endfunction

	always_comb begin
		rb1_d = ready_busy_out;
		rb2_d = rb1_q;
		rb3_d = rb2_q;
		rb_d = (rb2_q == rb3_q) ? rb3_q : rb_q;
		st_d = st_q;
		cnt_d = (cnt_q != 0) ? cnt_q - 32'd1 : cnt_q;
		ce_n_d = ce_n_q;
		cle_d = cle_q;
		ale_d = ale_q;
		we_n_d = we_n_q;
		re_n_d = re_n_q;
		io_oe_d = io_oe_q;
		io_d = io_q;
		ready_d = 1'b0;
		rv_d = 1'b0;
		rsp_d = rsp_q;
		bad_d = bad_q;
		fail_d = fail_q;
		init_d = init_q;
		rst_sent_d = rst_sent_q;
		last_addr_d = last_addr_q;
		rd_d = rd_q;
		is_status_d = is_status_q;
		last_cmd_d = last_cmd_q;
		row_d = row_q;
		pp_row_d = pp_row_q;
		pp_cnt_d = pp_cnt_q;
		// program confirm that would exceed the partial program count on this page
		over_nop = (req_phase == NFH_PH_CMD) && (req_data == 8'h00_10) && (last_cmd_q == 8'h00_80) &&
			(pp_row_q == row_q) && (pp_cnt_q == 3'(`NFH_NOP_MAX));
		unique case (st_q)
			NFH_S_PWR: begin
				// first command is reset once rb is high
				if (rb_q && !rst_sent_q) begin
					ce_n_d = 1'b0;
					cle_d = 1'b1;
					io_d = `NFH_CMD_RESET;
					io_oe_d = 1'b1;
					we_n_d = 1'b0;
					rd_d = 1'b0;
					rst_sent_d = 1'b1;
					cnt_d = 32'(`NFH_WC_CYC);
					st_d = NFH_S_LOW;
				end
			end
			NFH_S_IDLE: begin
				ready_d = !req_valid;
				if (req_valid && cnt_q == 0) begin
					if (over_nop) begin
						// confirm dropped and flagged; next command clears the loaded page
						fail_d = 1'b1;
					end else begin
						ce_n_d = 1'b0;
						cle_d = (req_phase == NFH_PH_CMD);
						ale_d = (req_phase == NFH_PH_ADDR);
						rd_d = req_read;
						io_d = req_data;
						io_oe_d = !req_read;
						we_n_d = req_read;
						re_n_d = !req_read;
						is_status_d = (req_phase == NFH_PH_CMD && req_data == `NFH_CMD_STATUS) ? 1'b1 :
							(req_phase == NFH_PH_CMD) ? 1'b0 : is_status_q;
						cnt_d = 32'(`NFH_WC_CYC);
						st_d = NFH_S_LOW;
						if (req_phase == NFH_PH_CMD)
							last_cmd_d = req_data;
						// last two address bytes form the row
						if (req_phase == NFH_PH_ADDR)
							row_d = {row_q[7:0], req_data};
						// count programs of one page; another page restarts the count
						if (req_phase == NFH_PH_CMD && req_data == 8'h00_10 && last_cmd_q == 8'h00_80) begin
							pp_cnt_d = (pp_row_q == row_q) ? pp_cnt_q + 3'd1 : 3'd1;
							pp_row_d = row_q;
						end
						// erase confirm frees the pages again
						if (req_phase == NFH_PH_CMD && req_data == 8'h00_D0)
							pp_cnt_d = 3'd0;
					end
				end
			end
			NFH_S_LOW: if (cnt_q == 0) begin
				we_n_d = 1'b1;
				re_n_d = 1'b1;
				if (rd_q) begin
					rsp_d = io_in;
					rv_d = 1'b1;
					// spare marker other than ff flags bad block
					bad_d = (io_in != `NFH_GOOD_MARK);
					// pass/fail bit after program or erase
					if (is_status_q)
						fail_d = io_in[`NFH_ST_FAIL];
				end
				cnt_d = 32'(`NFH_WC_CYC);
				st_d = NFH_S_HIGH;
			end
			NFH_S_HIGH: if (cnt_q == 0) begin
				cle_d = 1'b0;
				ale_d = 1'b0;
				io_oe_d = 1'b0;
				// hold gap after last address before data
				last_addr_d = ale_q;
				cnt_d = ale_q ? 32'(`NFH_ADL_CYC) : 32'd0;
				if (starts_busy(cle_q, io_q)) begin
					// busy may not show yet; hold off new commands
					cnt_d = 32'(`NFH_WB_CYC);
					st_d = NFH_S_WB;
				end else begin
					st_d = rst_sent_q && init_q ? NFH_S_IDLE : NFH_S_WAIT;
				end
			end
			NFH_S_WB: if (cnt_q == 0) begin
				cnt_d = rst_sent_q && !init_q ? 32'(RST_WAIT_CYC) : 32'd0;
				st_d = NFH_S_WAIT;
			end
			NFH_S_WAIT: begin
				// wait ready after each busy period
				// power-up reset also sits out its fixed wait
				if (rb_q && cnt_q == 0) begin
					init_d = 1'b1;
					cnt_d = 32'd0;
					st_d = NFH_S_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rb1_q <= 1'b0;
			rb2_q <= 1'b0;
			rb3_q <= 1'b0;
			rb_q <= 1'b0;
			st_q <= NFH_S_PWR;
			cnt_q <= 32'd0;
			ce_n_q <= 1'b1;
			cle_q <= 1'b0;
			ale_q <= 1'b0;
			we_n_q <= 1'b1;
			re_n_q <= 1'b1;
			io_oe_q <= 1'b0;
			io_q <= 8'h00_00;
			ready_q <= 1'b0;
			rv_q <= 1'b0;
			rsp_q <= 8'h00_00;
			bad_q <= 1'b0;
			fail_q <= 1'b0;
			init_q <= 1'b0;
			rst_sent_q <= 1'b0;
			last_addr_q <= 1'b0;
			rd_q <= 1'b0;
			is_status_q <= 1'b0;
			last_cmd_q <= 8'h00_00;
			row_q <= 16'h0000;
			pp_row_q <= 16'h0000;
			pp_cnt_q <= 3'h0;
		end else begin
			rb1_q <= rb1_d;
			rb2_q <= rb2_d;
			rb3_q <= rb3_d;
			rb_q <= rb_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			ce_n_q <= ce_n_d;
			cle_q <= cle_d;
			ale_q <= ale_d;
			we_n_q <= we_n_d;
			re_n_q <= re_n_d;
			io_oe_q <= io_oe_d;
			io_q <= io_d;
			ready_q <= ready_d;
			rv_q <= rv_d;
			rsp_q <= rsp_d;
			bad_q <= bad_d;
			fail_q <= fail_d;
			init_q <= init_d;
			rst_sent_q <= rst_sent_d;
			last_addr_q <= last_addr_d;
			rd_q <= rd_d;
			is_status_q <= is_status_d;
			last_cmd_q <= last_cmd_d;
			row_q <= row_d;
			pp_row_q <= pp_row_d;
			pp_cnt_q <= pp_cnt_d;
		end
	end

	// all outputs straight from flops; wp low until the power-up reset is sent, then high
	assign req_ready = ready_q;
	assign rsp_data = rsp_q;
	assign rsp_valid = rv_q;
	assign bad_mark = bad_q;
	assign op_fail = fail_q;
	assign init_done = init_q;
	assign ce_n = ce_n_q;
	assign cle = cle_q;
	assign ale = ale_q;
	assign we_n = we_n_q;
	assign re_n = re_n_q;
	assign wp_n = rst_sent_q;
	assign io_out = io_q;
	assign io_oe = io_oe_q;
endmodule // nfh_host

// ==== tb/nfh_host_sva.sv ====
/* checker for nfh_host pins and flags.
   bound to nfh_host; one clock domain. */
module nfh_host_sva (
	// clock, reset
	input wire logic clk,
	input wire logic rst,
	// user side
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic bad_mark,
	input wire logic init_done,
	// flash pins
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic wp_n,
	input wire logic [7:0] io_out,
	input wire logic io_oe,
	input wire logic ready_busy_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	rst_pins_a: assert property ($fell(rst) |-> ce_n && we_n && re_n && !io_oe && !wp_n)
		else $error("pins not idle after reset");
	first_cmd_a: assert property ($fell(we_n) && !init_done |-> cle && io_out == 8'h00_FF)
		else $error("first command not reset");
	we_pulse_a: assert property ($fell(we_n) |=> !we_n ##1 we_n)
		else $error("write pulse length");
	adl_gap_a: assert property ($rose(we_n) && ale |=> we_n[*4])
		else $error("address to data gap");
	wb_wait_a: assert property ($rose(we_n) && cle && io_out inside {8'h00_30, 8'h00_10} |=> (we_n && re_n)[*3])
		else $error("command inside busy window");
	busy_hold_a: assert property (!ready_busy_out[*4] |-> !$fell(we_n) && !$fell(re_n))
		else $error("cycle started while busy");
	rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
		else $error("response not one cycle");
	mark_flag_a: assert property (rsp_valid |-> bad_mark == (rsp_data != 8'h00_FF))
		else $error("marker flag mismatch");
	cover property ($rose(init_done));
	cover property (rsp_valid && bad_mark);
	cover property (!ready_busy_out[*8]);
endmodule // nfh_host_sva

bind nfh_host nfh_host_sva u_sva (.clk, .rst, .rsp_valid, .rsp_data, .bad_mark, .init_done, .ce_n, .cle, .ale,
	.we_n, .re_n, .wp_n, .io_out, .io_oe, .ready_busy_out);

// ==== tb/nfh_flash_model.sv ====
/* behavioural nand flash on the nfh_host pins.
   sampled on the bench clk; busy length set by the bench. */
module nfh_flash_model (
	// clock
	input wire logic clk,
	// bench controls
	input wire logic [7:0] busy_len,
	input wire logic [7:0] mark,
	input wire logic fail,
	// pins
	input wire logic ce_n,
	input wire logic cle,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic [7:0] io_out,
	output logic [7:0] io_in,
	output logic ready_busy_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic we_q = 1'b1;
	logic first_q = 1'b1;
	logic [7:0] cmd_q = 8'h00_00;
	logic [7:0] last_q = 8'h00_00;
	logic [8:0] busy_q = 9'h000;
	assign ready_busy_out = (busy_q == 9'h000);
	// released bus shows the inverse, never a stale byte
	assign io_in = (!ce_n && !re_n) ?
		((cmd_q == 8'h00_70) ? {2'b00, ready_busy_out, 4'h0, fail} : mark) : ~last_q;
	always @(posedge clk) begin
		we_q <= we_n;
		if (!re_n) begin
			last_q <= io_in;
		end
		if (busy_q != 9'h000) begin
			busy_q <= busy_q - 9'h001;
		end
		if (we_n && !we_q && cle && !ce_n) begin
			cmd_q <= io_out;
			// busy one clk after the latch edge; first reset runs double
			if (io_out inside {8'h00_FF, 8'h00_30, 8'h00_10}) begin
				busy_q <= first_q ? {busy_len, 1'b0} : {1'b0, busy_len};
				first_q <= 1'b0;
			end
		end
	end
endmodule // nfh_flash_model

// ==== tb/tb.sv ====
/* bench for nfh_host with the flash model.
   short reset wait; 20 MHz clk. */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import nfh_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0;
	logic req_read = 1'b0;
	logic fail = 1'b0;
	nfh_phase_t req_phase = NFH_PH_CMD;
	logic [7:0] req_data = 8'h00_00;
	logic [7:0] mark = 8'h00_FF;
	logic [7:0] busy_len = 8'h00_06;
	logic [7:0] rsp_data, io_in, io_out;
	logic req_ready, rsp_valid, bad_mark, op_fail, init_done;
	logic ce_n, cle, ale, we_n, re_n, wp_n, io_oe, ready_busy_out;
	int err_count = 0;
	int checks_done = 0;
	nfh_host #(.RST_WAIT_CYC(10)) dut (.clk, .rst, .req_valid, .req_phase, .req_read, .req_data, .req_ready,
		.rsp_data, .rsp_valid, .bad_mark, .op_fail, .init_done, .ce_n, .cle, .ale, .we_n, .re_n, .wp_n,
		.io_in, .io_out, .io_oe, .ready_busy_out);
	nfh_flash_model u_flash (.clk, .busy_len, .mark, .fail, .ce_n, .cle, .we_n, .re_n, .io_out, .io_in,
		.ready_busy_out);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// held until a strobe falls: the take edge is internal
	task automatic xfer(input nfh_phase_t ph, input logic rd, input logic [7:0] d);
		int n = 0;
		@(negedge clk);
		req_valid = 1'b1;
		req_phase = ph;
		req_read = rd;
		req_data = d;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (we_n && re_n && n < 5000);
		chk_bit(we_n && re_n, 1'b0);
		@(negedge clk);
		req_valid = 1'b0;
		n = 0;
		while (rd && !rsp_valid && n < 10) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (rd) begin
			chk_bit(rsp_valid, 1'b1);
		end
	endtask
	task automatic t_mark(input logic [7:0] blk, input logic [7:0] m);
		@(negedge clk);
		mark = m;
		xfer(NFH_PH_CMD, 1'b0, 8'h00_00);
		xfer(NFH_PH_ADDR, 1'b0, blk);
		xfer(NFH_PH_CMD, 1'b0, 8'h00_30);
		xfer(NFH_PH_DATA, 1'b1, 8'h00_00);
		chk(rsp_data, m);
		chk_bit(bad_mark, m != 8'h00_FF);
	endtask
	task automatic t_prog(input logic f);
		@(negedge clk);
		fail = f;
		xfer(NFH_PH_CMD, 1'b0, 8'h00_80);
		xfer(NFH_PH_ADDR, 1'b0, 8'h00_00);
		xfer(NFH_PH_DATA, 1'b0, 8'h00_5A);
		xfer(NFH_PH_CMD, 1'b0, 8'h00_10);
		xfer(NFH_PH_CMD, 1'b0, 8'h00_70);
		xfer(NFH_PH_DATA, 1'b1, 8'h00_00);
		chk(rsp_data, {2'b00, 1'b1, 4'h0, f});
		chk_bit(op_fail, f);
	endtask
	// two more programs fill the page; the fifth confirm must be dropped
	task automatic t_nop();
		int n = 0;
		t_prog(1'b0);
		t_prog(1'b0);
		xfer(NFH_PH_CMD, 1'b0, 8'h00_80);
		xfer(NFH_PH_ADDR, 1'b0, 8'h00_00);
		xfer(NFH_PH_DATA, 1'b0, 8'h00_A5);
		@(negedge clk);
		req_valid = 1'b1;
		req_phase = NFH_PH_CMD;
		req_data = 8'h00_10;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (!op_fail && we_n && n < 50);
		@(negedge clk);
		req_valid = 1'b0;
		chk_bit(op_fail, 1'b1);
		chk_bit(we_n, 1'b1);
	endtask
	task automatic end_sim();
		$display("checks=%0d errors=%0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		repeat (500) @(posedge clk);
		chk_bit(init_done, 1'b1);
		chk_bit(wp_n, 1'b1);
		chk_bit(req_ready, 1'b1);
		// a single bad block, never block zero
		t_mark(8'h00_01, 8'h00_00);
		busy_len = 8'h00_28;
		t_mark(8'h00_00, 8'h00_FF);
		t_prog(1'b1);
		t_prog(1'b0);
		t_nop();
		end_sim();
	end
	// whole run needs about a thousand cycles
	initial begin
		#1_000_000;
		err_count++;
		end_sim();
	end
endmodule // tb
